// File: bench/synth_ctrl_regs_0_to_2_bench.sv
// Bench joining host and device ends over the control link.
// Assumes package field positions; expected words kept in a local model.
`timescale 1ns/10ps
`default_nettype none
module synth_control_regs_0_to_2_bench import synth_ctrl_pkg::*; ;
  logic        mclk = 1'b0, rstn = 1'b0, initStart = 1'b0, writeValid = 1'b0, pinDrive = 1'b0;
  logic        pinSelectMsb = 1'b0, refDivSrc = 1'b0, fbHalfSrc = 1'b0, analogLock = 1'b0;
  logic        digitalLock = 1'b0, readbackBit = 1'b0, refused;
  logic [31:0] writeWord = 32'h0;
  logic [31:0] initWords [6] = '{32'h00320038, 32'h20008fa1, 32'h00014042, 32'h0000000b, 32'h6180b23c,
                                 32'h00000005};
  logic        writeReady, writeRefused, initDone, syncFromPin, intMode, lockSpeedSelect;
  logic        refDoublerEnable, refHalveEnable, lockFunctionSelect, lowPower, lockModeMismatch;
  logic        deviceEnabled, vcoSelectStart;
  logic [15:0] intDivider;
  logic [11:0] fracNumerator, phaseStep, modulusActive;
  logic [1:0]  pumpLinearity, pumpTestSelect, modulatorNoiseSelect;
  logic [3:0]  pinOutputSelect;
  logic [9:0]  refDividerActive;
  logic [31:0] r0 = DIVIDER_WORD_RESET, r1 = MODULUS_PHASE_WORD_RESET, r2 = REFERENCE_NOISE_WORD_RESET;
  logic [11:0] modAct = MODULUS_PHASE_WORD_RESET[MODULUS_HI:MODULUS_LO];
  logic [9:0]  rAct = REFERENCE_NOISE_WORD_RESET[REF_DIV_HI:REF_DIV_LO];
  int          fails = 0, comparisons = 0, cyc = 0, vcoCount = 0, vcoExp = 0, idleRun = 0, idleMax = 0;
  // Out of range words, then accepted boundaries, low power and unused addresses
  localparam logic [31:0] BAD_WORDS [5] = '{32'h80078000, 32'h00090000, 32'h07fe0000, 32'h00000009,
                                            32'h00000042};
  localparam logic [31:0] GOOD_WORDS [9] = '{32'h00098008, 32'h07fd8000, 32'hffff8000, 32'h00014062,
                                             32'ha5a5a5a3, 32'ha5a5a5a4, 32'ha5a5a5a5, 32'ha5a5a5a6,
                                             32'ha5a5a5a7};

  synth_link_if link ();
  // Pin level from whoever drives it
  assign link.muxPinIn = link.muxPinOe ? link.muxPinOut : pinDrive;

  always #10 mclk = ~mclk;

  synth_ctrl_host #(.GAP_CYCLES(50), .HALF_CYCLES(4)) synth_ctrl_host_inst (.mclk(mclk), .rstn(rstn),
    .link(link), .initStart(initStart), .initWords(initWords), .writeValid(writeValid),
    .writeWord(writeWord), .writeReady(writeReady), .writeRefused(writeRefused), .initDone(initDone));

  synth_ctrl_device synth_ctrl_device_inst (.mclk(mclk), .rstn(rstn), .link(link),
    .pinSelectMsb(pinSelectMsb), .refDivSrc(refDivSrc), .fbHalfSrc(fbHalfSrc),
    .analogLock(analogLock), .digitalLock(digitalLock), .readbackBit(readbackBit),
    .syncFromPin(syncFromPin), .intMode(intMode), .intDivider(intDivider), .fracNumerator(fracNumerator),
    .pumpLinearity(pumpLinearity), .pumpTestSelect(pumpTestSelect), .phaseStep(phaseStep),
    .modulusActive(modulusActive), .lockSpeedSelect(lockSpeedSelect),
    .modulatorNoiseSelect(modulatorNoiseSelect), .pinOutputSelect(pinOutputSelect),
    .refDoublerEnable(refDoublerEnable), .refHalveEnable(refHalveEnable),
    .refDividerActive(refDividerActive), .lockFunctionSelect(lockFunctionSelect), .lowPower(lowPower),
    .lockModeMismatch(lockModeMismatch), .deviceEnabled(deviceEnabled), .vcoSelectStart(vcoSelectStart));

  synth_link_asserts #(.HALF(4)) synth_link_asserts_inst (.mclk(mclk), .rstn(rstn),
    .linkClk(link.linkClk), .linkData(link.linkData), .loadEnable(link.loadEnable),
    .muxPinOut(link.muxPinOut), .muxPinOe(link.muxPinOe));

  // Falling edge sampling avoids racing the design's own updates
  always @(negedge mclk) begin
    cyc++;
    if (vcoSelectStart === 1'b1) vcoCount++;
    // Longest quiet stretch of the link; only the pass gap reaches the gap count
    idleRun = (link.linkClk === 1'b0 && link.loadEnable === 1'b0) ? idleRun + 1 : 0;
    if (idleRun > idleMax) idleMax = idleRun;
    if (cyc == 40000) begin
      fails++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Expected registers; shadowed fields move with a divider word only
  task automatic model(input logic [31:0] w);
    case (w[ADDR_HI:0])
      DIVIDER_WORD_ADDR: begin
        r0 = w;
        modAct = r1[MODULUS_HI:MODULUS_LO];
        rAct = r2[REF_DIV_HI:REF_DIV_LO];
        vcoExp++;
      end
      MODULUS_PHASE_WORD_ADDR: r1 = {1'b0, w[30:0]};
      REFERENCE_NOISE_WORD_ADDR: r2 = w;
      default: ;
    endcase
  endtask

  task automatic checkAll();
    chk(32'(intMode), 32'(r0[INT_MODE_BIT]), "mode");
    chk(32'(intDivider), 32'(r0[INT_DIV_HI:INT_DIV_LO]), "int div");
    chk(32'(fracNumerator), 32'(r0[FRAC_HI:FRAC_LO]), "frac");
    chk(32'(pumpLinearity), 32'(r1[LINEARITY_HI:LINEARITY_LO]), "linearity");
    chk(32'(pumpTestSelect), 32'(r1[PUMP_TEST_HI:PUMP_TEST_LO]), "pump test");
    chk(32'(phaseStep), 32'(r1[PHASE_HI:PHASE_LO]), "phase");
    chk(32'(modulusActive), 32'(modAct), "modulus");
    chk(32'(lockSpeedSelect), 32'(r2[LOCK_SPEED_BIT]), "lock speed");
    chk(32'(modulatorNoiseSelect), 32'(r2[NOISE_HI:NOISE_LO]), "noise");
    chk(32'(pinOutputSelect), 32'({pinSelectMsb, r2[PIN_SEL_HI:PIN_SEL_LO]}), "pin select");
    chk(32'({refDoublerEnable, refHalveEnable}), 32'(r2[DOUBLER_BIT:HALVE_BIT]), "ref path");
    chk(32'(refDividerActive), 32'(rAct), "ref div");
    chk(32'(lockFunctionSelect), 32'(r2[LOCK_FUNC_BIT]), "lock func");
    chk(32'(lockModeMismatch), 32'(r0[INT_MODE_BIT] ^ r2[LOCK_FUNC_BIT]), "mode match");
    chk(32'(lowPower), 32'(r2[SHUTDOWN_BIT]), "low power");
    chk(32'(vcoCount), 32'(vcoExp), "vco starts");
  endtask

  // One word through the host; ready must be high at entry
  task automatic put(input logic [31:0] w, input logic bad);
    int n;
    refused = 1'b0;
    n = 0;
    writeValid = 1'b1;
    writeWord = w;
    tick(1);
    writeValid = 1'b0;
    do begin
      tick(1);
      n++;
      if (writeRefused === 1'b1) refused = 1'b1;
    end while (writeReady !== 1'b1 && n < 2000);
    tick(4);
    chk(32'(refused), 32'(bad), "refusal");
    if (!bad) model(w);
    checkAll();
  endtask

  initial begin
    tick(2);
    rstn = 1'b1;
    checkAll();
    $display("test reset done");
    // Power-up double pass; register 0 goes last in each pass
    initStart = 1'b1;
    tick(1);
    initStart = 1'b0;
    for (int i = 0; i < 20000 && initDone !== 1'b1; i++) tick(1);
    chk(32'(initDone), 32'h1, "init done");
    tick(4);
    model(initWords[1]);
    model(initWords[2]);
    model(initWords[0]);
    checkAll();
    chk(32'(deviceEnabled), 32'h1, "enabled");
    chk(32'(idleMax >= 50), 32'h1, "pass gap");
    $display("test init done");
    // Shadowed fields wait for the divider word
    put(32'h7091d5e1, 1'b0);
    put(32'he2ffc142, 1'b0);
    put(32'h80080000, 1'b0);
    $display("test shadow done");
    foreach (BAD_WORDS[i]) put(BAD_WORDS[i], 1'b1);
    foreach (GOOD_WORDS[i]) put(GOOD_WORDS[i], 1'b0);
    $display("test ranges done");
    // Every pump code, every pin code; reserved low bits stay at defaults
    for (int k = 0; k < 8; k++) begin
      pinDrive = (k == 7);
      refDivSrc = (k == 3);
      fbHalfSrc = (k == 4);
      analogLock = (k == 5);
      digitalLock = (k == 6);
      readbackBit = (k == 4);
      if (k < 4) put({1'b0, 2'(k), 2'(3 - k), 12'(k), 12'(k + 2), 3'h1}, 1'b0);
      put({k[0], k[2:1], k[2:0], k[1], k[2], 10'(k + 1), 5'h00, k[0], 8'h42}, 1'b0);
      tick(4);
      chk(32'({link.muxPinOe, link.muxPinOe & link.muxPinOut}), 32'({2{k > 0 && k < 7}} & {1'b1, k != 2}),
          "pin");
      if (k == 0 || k == 7) chk(32'(syncFromPin), 32'(k == 7), "sync");
      pinSelectMsb = 1'b1;
      tick(2);
      chk(32'({link.muxPinOe, link.muxPinOe & link.muxPinOut}), 32'({2{k == 4}}), "pin high");
      pinSelectMsb = 1'b0;
    end
    $display("test fields done");
    // Mid-run reset puts every register back to its reset word
    rstn = 1'b0;
    tick(2);
    rstn = 1'b1;
    r0 = DIVIDER_WORD_RESET;
    r1 = MODULUS_PHASE_WORD_RESET;
    r2 = REFERENCE_NOISE_WORD_RESET;
    modAct = MODULUS_PHASE_WORD_RESET[MODULUS_HI:MODULUS_LO];
    rAct = REFERENCE_NOISE_WORD_RESET[REF_DIV_HI:REF_DIV_LO];
    checkAll();
    chk(32'(deviceEnabled), 32'h0, "enable cleared");
    $display("test reset again done");
    give_verdict();
  end
endmodule // synth_control_regs_0_to_2_bench
`default_nettype wire

// File: bench/synth_link_asserts.sv
// Timing checks for the control word link between host and device ends.
// Assumes the host runs with a link half period of HALF mclk cycles.
`timescale 1ns/10ps
`default_nettype none
module synth_link_asserts #(
  parameter int HALF = 4
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic linkClk,
  input wire logic linkData,
  input wire logic loadEnable,
  input wire logic muxPinOut,
  input wire logic muxPinOe
);
  logic [7:0] hiRun_q, hiRun_d, rises_q, rises_d;
  logic       clkPrev_q, clkPrev_d, loadPrev_q, loadPrev_d;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  // Clock high time and rises since the last load; cleared in reset
  always_comb begin
    hiRun_d = (rstn && linkClk) ? hiRun_q + 8'h01 : 8'h00;
    clkPrev_d = rstn && linkClk;
    loadPrev_d = rstn && loadEnable;
    rises_d = rises_q;
    if (!rstn || (loadEnable && !loadPrev_q)) begin
      rises_d = 8'h00;
    end else if (linkClk && !clkPrev_q) begin
      rises_d = rises_q + 8'h01;
    end
  end

  // Helper registers only
  always_ff @(posedge mclk) begin
    hiRun_q <= hiRun_d;
    rises_q <= rises_d;
    clkPrev_q <= clkPrev_d;
    loadPrev_q <= loadPrev_d;
  end

  clk_high_len_a: assert property ($fell(linkClk) |-> hiRun_q == 8'(HALF))
    else $error("link clock high time wrong");
  clk_low_len_a: assert property ($fell(linkClk) |-> !linkClk [*4])
    else $error("link clock low time too short");
  data_hold_a: assert property (linkClk && $past(linkClk) |-> $stable(linkData))
    else $error("data moved while clock high");
  data_shift_a: assert property ($changed(linkData) |-> !linkClk)
    else $error("data changed with clock high");
  load_gap_a: assert property (loadEnable |-> !linkClk)
    else $error("load strobe overlaps clock");
  load_len_a: assert property ($rose(loadEnable) |-> loadEnable [*4] ##1 !loadEnable)
    else $error("load strobe length wrong");
  word_bits_a: assert property ($rose(loadEnable) |-> rises_q == 8'h20)
    else $error("word not 32 clocks long");
  reset_idle_a: assert property ($rose(rstn) |-> !linkClk && !loadEnable && !muxPinOe)
    else $error("link not idle after reset");

  word_load_c: cover property ($rose(loadEnable));
  pin_drive_c: cover property ($rose(muxPinOe) ##1 muxPinOut);
  two_words_c: cover property ($fell(loadEnable) ##[1:40] $rose(linkClk));
endmodule // synth_link_asserts
`default_nettype wire

// File: inc/synth_ctrl_pkg.sv
// Shared constants for the synthesizer control word link.
// Assumes both ends import it; words are 32 bits, MSB first.
package synth_ctrl_pkg;
  localparam int WORD_BITS = 32;
  // Address field and register indices
  localparam int ADDR_HI = 2;
  localparam logic [2:0] DIVIDER_WORD_ADDR = 3'h0;
  localparam logic [2:0] MODULUS_PHASE_WORD_ADDR = 3'h1;
  localparam logic [2:0] REFERENCE_NOISE_WORD_ADDR = 3'h2;
  localparam logic [2:0] LAST_WORD_ADDR = 3'h5;
  // Reset values
  localparam logic [31:0] DIVIDER_WORD_RESET = 32'h007d0000;
  localparam logic [31:0] MODULUS_PHASE_WORD_RESET = 32'h2000fff9;
  localparam logic [31:0] REFERENCE_NOISE_WORD_RESET = 32'h00004042;
  // Divider word fields
  localparam int INT_MODE_BIT = 31;
  localparam int INT_DIV_HI = 30;
  localparam int INT_DIV_LO = 15;
  localparam int FRAC_HI = 14;
  localparam int FRAC_LO = 3;
  // Modulus and phase word fields
  localparam int RESERVED_M_BIT = 31;
  localparam int LINEARITY_HI = 30;
  localparam int LINEARITY_LO = 29;
  localparam int PUMP_TEST_HI = 28;
  localparam int PUMP_TEST_LO = 27;
  localparam int PHASE_HI = 26;
  localparam int PHASE_LO = 15;
  localparam int MODULUS_HI = 14;
  localparam int MODULUS_LO = 3;
  // Reference and noise word fields
  localparam int LOCK_SPEED_BIT = 31;
  localparam int NOISE_HI = 30;
  localparam int NOISE_LO = 29;
  localparam int PIN_SEL_HI = 28;
  localparam int PIN_SEL_LO = 26;
  localparam int DOUBLER_BIT = 25;
  localparam int HALVE_BIT = 24;
  localparam int REF_DIV_HI = 23;
  localparam int REF_DIV_LO = 14;
  localparam int LOCK_FUNC_BIT = 8;
  localparam int SHUTDOWN_BIT = 5;
  // Allowed ranges
  localparam logic [15:0] INT_DIV_MIN_INT = 16'h0010;
  localparam logic [15:0] INT_DIV_MIN_FRAC = 16'h0013;
  localparam logic [15:0] INT_DIV_MAX_FRAC = 16'h0ffb;
  localparam logic [11:0] MODULUS_MIN = 12'h002;
  // Multiplexed pin codes
  localparam logic [3:0] PIN_TRISTATE = 4'h0;
  localparam logic [3:0] PIN_HIGH = 4'h1;
  localparam logic [3:0] PIN_LOW = 4'h2;
  localparam logic [3:0] PIN_REF_DIV = 4'h3;
  localparam logic [3:0] PIN_FB_HALF = 4'h4;
  localparam logic [3:0] PIN_ANALOG_LOCK = 4'h5;
  localparam logic [3:0] PIN_DIGITAL_LOCK = 4'h6;
  localparam logic [3:0] PIN_SYNC_IN = 4'h7;
  localparam logic [3:0] PIN_READBACK = 4'hc;
  // Timing
  localparam int CLOCK_HZ = 50_000_000;
  localparam int PASS_GAP_MS = 20;
  localparam int PASS_GAP_CYCLES = CLOCK_HZ / 1000 * PASS_GAP_MS;
  localparam int LINK_PERIOD_NS = 160;
  localparam int LINK_HALF_CYCLES = LINK_PERIOD_NS / 2 / (1_000_000_000 / CLOCK_HZ);
endpackage

// File: inc/synth_link_if.sv
// Four-wire control link: clock, data, load strobe, multiplexed pin.
// Assumes the bench resolves the pin level from muxPinOe.
`timescale 1ns/10ps
`default_nettype none
interface synth_link_if;
  logic linkClk;
  logic linkData;
  logic loadEnable;
  logic muxPinOut;
  logic muxPinOe;
  logic muxPinIn;
  modport device (input linkClk, input linkData, input loadEnable,
                  output muxPinOut, output muxPinOe, input muxPinIn);
  modport host (output linkClk, output linkData, output loadEnable,
                input muxPinIn);
endinterface
`default_nettype wire

// File: verilog/synth_ctrl_device.sv
// Device end: serial word receiver, control registers 0..2, pin mux.
// Assumes link pins arrive asynchronously and are synchronised here.
`timescale 1ns/10ps
`default_nettype none
module synth_ctrl_device
  import synth_ctrl_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rstn,
  synth_link_if.device     link,
  input  wire logic        pinSelectMsb,
  input  wire logic        refDivSrc,
  input  wire logic        fbHalfSrc,
  input  wire logic        analogLock,
  input  wire logic        digitalLock,
  input  wire logic        readbackBit,
  output logic             syncFromPin,
  output logic             intMode,
  output logic [15:0]      intDivider,
  output logic [11:0]      fracNumerator,
  output logic [1:0]       pumpLinearity,
  output logic [1:0]       pumpTestSelect,
  output logic [11:0]      phaseStep,
  output logic [11:0]      modulusActive,
  output logic             lockSpeedSelect,
  output logic [1:0]       modulatorNoiseSelect,
  output logic [3:0]       pinOutputSelect,
  output logic             refDoublerEnable,
  output logic             refHalveEnable,
  output logic [9:0]       refDividerActive,
  output logic             lockFunctionSelect,
  output logic             lowPower,
  output logic             lockModeMismatch,
  output logic             deviceEnabled,
  output logic             vcoSelectStart
);
  // Bit order of the synchronised vector: clock, data, load, pin
  localparam int SYNC_W = 4;

  logic [SYNC_W-1:0] sync1_q, sync2_q, sync3_q, level_q, level_d;
  logic              clkRise, loadRise, dataNow;

  // Three-flop capture; a level counts once stages two and three agree
  always_comb begin
    level_d = level_q;
    for (int i = 0; i < SYNC_W; i++) begin
      if (sync2_q[i] == sync3_q[i]) begin
        level_d[i] = sync3_q[i];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      level_q <= '0;
    end else begin
      sync1_q <= {link.muxPinIn, link.loadEnable, link.linkData, link.linkClk};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      level_q <= level_d;
    end
  end

  // Edges seen in the filtered levels
  assign clkRise  = level_d[0] & ~level_q[0];
  assign loadRise = level_d[2] & ~level_q[2];
  assign dataNow  = level_d[1];
  assign syncFromPin = level_q[3];

  logic [31:0] shift_q, shift_d;
  logic [31:0] divWord_q, divWord_d;
  logic [31:0] modPhase_q, modPhase_d;
  logic [31:0] refNoise_q, refNoise_d;
  logic [11:0] modulusActive_q, modulusActive_d;
  logic [9:0]  refDivActive_q, refDivActive_d;
  logic        enabled_q, enabled_d;
  logic        vcoStart_q, vcoStart_d;
  logic [2:0]  wordAddr;

  assign wordAddr = shift_q[ADDR_HI:0];

  // Word capture, routing and double-buffer transfer
  always_comb begin
    shift_d         = shift_q;
    divWord_d       = divWord_q;
    modPhase_d      = modPhase_q;
    refNoise_d      = refNoise_q;
    modulusActive_d = modulusActive_q;
    refDivActive_d  = refDivActive_q;
    enabled_d       = enabled_q;
    vcoStart_d      = 1'b0;
    if (clkRise) begin
      shift_d = {shift_q[30:0], dataNow};     // MSB arrives first
    end
    if (loadRise) begin
      case (wordAddr)
        DIVIDER_WORD_ADDR: begin
          divWord_d = shift_q;
          modulusActive_d = modPhase_q[MODULUS_HI:MODULUS_LO];
          refDivActive_d = refNoise_q[REF_DIV_HI:REF_DIV_LO];
          enabled_d = 1'b1;
          vcoStart_d = enabled_q;
        end
        MODULUS_PHASE_WORD_ADDR: begin
          modPhase_d = shift_q;
        end
        REFERENCE_NOISE_WORD_ADDR: begin
          refNoise_d = shift_q;
        end
        default: begin
          // Words for registers 3..5 belong to other blocks
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      shift_q         <= '0;
      divWord_q       <= DIVIDER_WORD_RESET;
      modPhase_q      <= MODULUS_PHASE_WORD_RESET;
      refNoise_q      <= REFERENCE_NOISE_WORD_RESET;
      modulusActive_q <= MODULUS_PHASE_WORD_RESET[MODULUS_HI:MODULUS_LO];
      refDivActive_q  <= REFERENCE_NOISE_WORD_RESET[REF_DIV_HI:REF_DIV_LO];
      enabled_q       <= 1'b0;
      vcoStart_q      <= 1'b0;
    end else begin
      shift_q         <= shift_d;
      divWord_q       <= divWord_d;
      modPhase_q      <= modPhase_d;
      refNoise_q      <= refNoise_d;
      modulusActive_q <= modulusActive_d;
      refDivActive_q  <= refDivActive_d;
      enabled_q       <= enabled_d;
      vcoStart_q      <= vcoStart_d;
    end
  end

  // fields decoded from register contents; the pin select MSB comes from pinSelectMsb
  assign intMode = divWord_q[INT_MODE_BIT];
  assign intDivider = divWord_q[INT_DIV_HI:INT_DIV_LO];
  assign fracNumerator = divWord_q[FRAC_HI:FRAC_LO];
  assign pumpLinearity = modPhase_q[LINEARITY_HI:LINEARITY_LO];
  assign pumpTestSelect = modPhase_q[PUMP_TEST_HI:PUMP_TEST_LO];
  assign phaseStep = modPhase_q[PHASE_HI:PHASE_LO];
  assign modulusActive = modulusActive_q;
  assign lockSpeedSelect = refNoise_q[LOCK_SPEED_BIT];
  assign modulatorNoiseSelect = refNoise_q[NOISE_HI:NOISE_LO];
  assign pinOutputSelect = {pinSelectMsb, refNoise_q[PIN_SEL_HI:PIN_SEL_LO]};
  assign refDoublerEnable = refNoise_q[DOUBLER_BIT];
  assign refHalveEnable = refNoise_q[HALVE_BIT];
  assign refDividerActive = refDivActive_q;
  assign lockFunctionSelect = refNoise_q[LOCK_FUNC_BIT];
  assign lowPower = refNoise_q[SHUTDOWN_BIT];
  // flag a lock mode that disagrees
  assign lockModeMismatch = intMode ^ lockFunctionSelect;
  assign deviceEnabled = enabled_q;
  assign vcoSelectStart = vcoStart_q;

  logic pinOut_q, pinOut_d, pinOe_q, pinOe_d;

  // multiplexed pin source; reserved codes float
  always_comb begin
    pinOut_d = 1'b0;
    pinOe_d  = 1'b1;
    case (pinOutputSelect)
      PIN_HIGH:         pinOut_d = 1'b1;
      PIN_LOW:          pinOut_d = 1'b0;
      PIN_REF_DIV:      pinOut_d = refDivSrc;
      PIN_FB_HALF:      pinOut_d = fbHalfSrc;
      PIN_ANALOG_LOCK:  pinOut_d = analogLock;
      PIN_DIGITAL_LOCK: pinOut_d = digitalLock;
      PIN_READBACK:     pinOut_d = readbackBit;
      PIN_TRISTATE, PIN_SYNC_IN: pinOe_d = 1'b0;
      default:          pinOe_d = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pinOut_q <= 1'b0;
      pinOe_q  <= 1'b0;
    end else begin
      pinOut_q <= pinOut_d;
      pinOe_q  <= pinOe_d;
    end
  end

  assign link.muxPinOut = pinOut_q;
  assign link.muxPinOe  = pinOe_q;
endmodule // synth_ctrl_device
`default_nettype wire

// File: verilog/synth_ctrl_host.sv
// Host end: power-up double pass and single word writes over the link.
// Assumes one mclk domain; the link clock is divided down here.
`timescale 1ns/10ps
`default_nettype none
module synth_ctrl_host
  import synth_ctrl_pkg::*;
#(
  parameter int GAP_CYCLES = PASS_GAP_CYCLES,
  parameter int HALF_CYCLES = LINK_HALF_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        rstn,
  synth_link_if.host       link,
  input  wire logic        initStart,
  input  wire logic [31:0] initWords [6],
  input  wire logic        writeValid,
  input  wire logic [31:0] writeWord,
  output logic             writeReady,
  output logic             writeRefused,
  output logic             initDone
);
  // Half periods under 3 cycles are rejected; under 2 cycles they are dropped by the device's pin filter
  if (GAP_CYCLES < 1 || HALF_CYCLES < 3) begin : gen_timing_check
    $error("host timing parameters out of range");
  end

  typedef enum logic [2:0] {
    IDLE_S  = 3'b000,
    PICK_S  = 3'b001,
    SHIFT_S = 3'b010,
    LOAD_S  = 3'b011,
    GAP_S   = 3'b100
  } state_type;

  state_type   state_q, state_d;
  logic [31:0] word_q, word_d, cand;
  logic [5:0]  bitCnt_q, bitCnt_d;
  logic [2:0]  idx_q, idx_d;
  logic        pass_q, pass_d, init_q, init_d;
  logic        sclk_q, sclk_d, le_q, le_d, refused_q, refused_d, done_q, done_d;
  logic [31:0] timer_q, timer_d;
  logic        halfTick, candOk;

  assign halfTick = (timer_q == 32'h0);

  // address field forced to the target during the power-up pass; single writes keep their own
  always_comb begin
    cand = init_q ? initWords[idx_q] : writeWord;
    if (init_q) begin
      cand[ADDR_HI:0] = idx_q;
    end
    if (cand[ADDR_HI:0] == MODULUS_PHASE_WORD_ADDR) begin
      cand[RESERVED_M_BIT] = 1'b0;
    end
  end

  // divider range; modulus range; reference divider nonzero
  always_comb begin
    case (cand[ADDR_HI:0])
      DIVIDER_WORD_ADDR:
        candOk = cand[INT_MODE_BIT] ? (cand[INT_DIV_HI:INT_DIV_LO] >= INT_DIV_MIN_INT)
               : (cand[INT_DIV_HI:INT_DIV_LO] >= INT_DIV_MIN_FRAC &&
                  cand[INT_DIV_HI:INT_DIV_LO] <= INT_DIV_MAX_FRAC);
      MODULUS_PHASE_WORD_ADDR: candOk = cand[MODULUS_HI:MODULUS_LO] >= MODULUS_MIN;
      REFERENCE_NOISE_WORD_ADDR: candOk = cand[REF_DIV_HI:REF_DIV_LO] != 10'h000;
      default: candOk = 1'b1;
    endcase
  end

  assign writeReady = (state_q == IDLE_S) && !initStart;

  // Sequencer: words of each pass go 5 down to 0, divider word last
  always_comb begin
    state_d   = state_q;
    word_d    = word_q;
    bitCnt_d  = bitCnt_q;
    idx_d     = idx_q;
    pass_d    = pass_q;
    init_d    = init_q;
    sclk_d    = sclk_q;
    le_d      = le_q;
    refused_d = 1'b0;
    done_d    = 1'b0;
    timer_d   = halfTick ? 32'(HALF_CYCLES - 1) : timer_q - 32'h1;
    case (state_q)
      IDLE_S: begin
        if (initStart) begin
          init_d  = 1'b1;
          pass_d  = 1'b0;
          idx_d   = LAST_WORD_ADDR;
          state_d = PICK_S;
        end else if (writeValid) begin
          state_d = PICK_S;
        end
      end
      PICK_S: begin
        if (candOk) begin
          word_d   = cand;
          bitCnt_d = 6'h20;
          timer_d  = 32'(HALF_CYCLES - 1);
          state_d  = SHIFT_S;
        end else begin
          refused_d = 1'b1;
          state_d   = LOAD_S;
          timer_d   = 32'h0;
        end
      end
      SHIFT_S: begin
        if (halfTick) begin
          if (sclk_q) begin
            sclk_d   = 1'b0;
            word_d   = {word_q[30:0], 1'b0};
            bitCnt_d = bitCnt_q - 6'h1;
          end else if (bitCnt_q == 6'h0) begin
            le_d    = 1'b1;
            state_d = LOAD_S;
          end else begin
            sclk_d = 1'b1;
          end
        end
      end
      LOAD_S: begin
        if (halfTick) begin
          le_d = 1'b0;
          if (!init_q) begin
            state_d = IDLE_S;
          end else if (idx_q != DIVIDER_WORD_ADDR) begin
            idx_d   = idx_q - 3'h1;
            state_d = PICK_S;
          end else if (!pass_q) begin
            pass_d  = 1'b1;
            idx_d   = LAST_WORD_ADDR;
            timer_d = 32'(GAP_CYCLES - 1);
            state_d = GAP_S;
          end else begin
            init_d  = 1'b0;
            done_d  = 1'b1;
            state_d = IDLE_S;
          end
        end
      end
      GAP_S: begin
        if (halfTick) begin
          state_d = PICK_S;
        end
      end
      default: state_d = IDLE_S;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_q   <= IDLE_S;
      word_q    <= '0;
      bitCnt_q  <= '0;
      idx_q     <= '0;
      pass_q    <= 1'b0;
      init_q    <= 1'b0;
      sclk_q    <= 1'b0;
      le_q      <= 1'b0;
      refused_q <= 1'b0;
      done_q    <= 1'b0;
      timer_q   <= '0;
    end else begin
      state_q   <= state_d;
      word_q    <= word_d;
      bitCnt_q  <= bitCnt_d;
      idx_q     <= idx_d;
      pass_q    <= pass_d;
      init_q    <= init_d;
      sclk_q    <= sclk_d;
      le_q      <= le_d;
      refused_q <= refused_d;
      done_q    <= done_d;
      timer_q   <= timer_d;
    end
  end

  assign link.linkClk    = sclk_q;
  assign link.linkData   = word_q[31];
  assign link.loadEnable = le_q;
  assign writeRefused    = refused_q;
  assign initDone        = done_q;
endmodule // synth_ctrl_host
`default_nettype wire
